// ### pic_defs.svh
/*
  Constants of the priority interrupt controller: port offsets, field
  positions, command codes and reset values.
  Assumes it is included by its bare name from the controller files.
*/
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// ----------------------------------------------------------------------
// Port offsets
// ----------------------------------------------------------------------
`define PIC_PORT_EVEN     8'hc0
`define PIC_PORT_ODD      8'hc2
`define PIC_PORT_EVEN_ALT 8'hc4
`define PIC_PORT_ODD_ALT  8'hc6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PIC_W1_IC4   0
`define PIC_W1_SNGL  1
`define PIC_W1_LTIM  3
`define PIC_W1_ID    4
`define PIC_W4_UPM   0
`define PIC_W4_AEOI  1
`define PIC_W4_MS    2
`define PIC_W4_BUF   3
`define PIC_W4_SFNM  4
`define PIC_SS_RIS   0
`define PIC_SS_RR    1
`define PIC_SS_FLAG  3
`define PIC_SS_SMM   5
`define PIC_SS_ESMM  6

// ----------------------------------------------------------------------
// Priority command codes, bits 7..5
// ----------------------------------------------------------------------
`define PIC_PC_AEOI_CLR 3'h0
`define PIC_PC_EOI      3'h1
`define PIC_PC_LINE_SPECIFIC_END     3'h3
`define PIC_PC_AEOI_SET 3'h4
`define PIC_PC_ROT_EOI  3'h5
`define PIC_PC_SET_PRI  3'h6
`define PIC_PC_ROT_LINE_SPECIFIC_END 3'h7

// ----------------------------------------------------------------------
// Reset values and spurious line
// ----------------------------------------------------------------------
`define PIC_RST_MASK    8'h00
`define PIC_RST_LOWEST  3'h7
`define PIC_SPURIOUS    3'h7

`endif

// ### pic_pkg.sv
/*
  Types shared by the priority interrupt controller modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pic_pkg;

  typedef logic [7:0] pic_byte_t;
  typedef logic [2:0] pic_line_t;

  // Gray along the usual initialization path
  typedef enum logic [2:0] {
    PIC_INIT_IDLE  = 3'b000,
    PIC_INIT_VEC   = 3'b001,
    PIC_INIT_CAS   = 3'b011,
    PIC_INIT_MODE  = 3'b010,
    PIC_INIT_READY = 3'b110
  } pic_init_e;

  typedef enum logic [1:0] {
    PIC_ACK_IDLE = 2'b00,
    PIC_ACK_ONE  = 2'b01,
    PIC_ACK_TWO  = 2'b11
  } pic_ack_e;

endpackage

// ### pic_res_if.sv
/*
  Carrier between the controller core and its priority resolver.
  Assumes both ends run on the same clock; the resolver is combinational.
*/
interface pic_res_if;
  pic_pkg::pic_byte_t req;
  pic_pkg::pic_byte_t in_service_status;
  pic_pkg::pic_byte_t mask;
  pic_pkg::pic_byte_t smap;
  pic_pkg::pic_line_t low;
  logic               smm;
  logic               special_nesting_select;
  logic               int_req;
  pic_pkg::pic_line_t win;
  pic_pkg::pic_line_t top;
  logic               top_any;

  modport res (input req, in_service_status, mask, smap, low, smm, special_nesting_select,
               output int_req, win, top, top_any);
  modport ctl (output req, in_service_status, mask, smap, low, smm, special_nesting_select,
               input int_req, win, top, top_any);
endinterface

// ### pic_resolver.sv
/*
  Priority resolver: picks the best unmasked request under the current
  rotation and decides whether it may interrupt what is in service.
  Assumes the core drives every input of the carrier each cycle.
*/
module pic_resolver (
  pic_res_if.res r
);

  // --------------------------------------------------------------------
  // Rank of a line, zero is highest
  // --------------------------------------------------------------------
  function automatic pic_pkg::pic_line_t rank(input pic_pkg::pic_line_t ln,
                                              input pic_pkg::pic_line_t lo);
    rank = ln - lo - 3'h1;
  endfunction

  pic_pkg::pic_byte_t pend;
  pic_pkg::pic_byte_t blk;
  pic_pkg::pic_line_t ln;
  pic_pkg::pic_line_t rq_line;
  pic_pkg::pic_line_t bk_line;
  logic               rq_hit;
  logic               bk_hit;

  // --------------------------------------------------------------------
  // Scan from lowest rank upward so the highest one lands last
  // --------------------------------------------------------------------
  always_comb begin
    pend      = r.req & ~r.mask;
    blk       = r.smm ? 8'h00 : r.in_service_status;
    if (r.smm) begin
      pend = pend & ~r.in_service_status;
    end
    rq_hit    = 1'b0;
    bk_hit    = 1'b0;
    rq_line   = 3'h0;
    bk_line   = 3'h0;
    r.top     = 3'h0;
    r.top_any = 1'b0;
    for (int p = 7; p >= 0; p--) begin
      ln = r.low + 3'h1 + p[2:0];
      if (pend[ln]) begin
        rq_hit  = 1'b1;
        rq_line = ln;
      end
      if (blk[ln]) begin
        bk_hit  = 1'b1;
        bk_line = ln;
      end
      if (r.in_service_status[ln]) begin
        r.top_any = 1'b1;
        r.top     = ln;
      end
    end
    r.win     = rq_line;
    // Equal level passes only for a slave line in special nesting
    r.int_req = rq_hit && (!bk_hit || (rank(rq_line, r.low) < rank(bk_line, r.low)) ||
                (r.special_nesting_select && rq_line == bk_line && r.smap[rq_line]));
  end

endmodule

// ### pic_ctrl.sv
/*
  Eight-input priority interrupt controller: command and status ports,
  initialization sequence, request and in-service tracking, acknowledge
  sequence with cascade lines and vector output.
  Assumes WR_I/RD_I come from logic on SYS_CLK_I; IR_I, INTERRUPT_ACKNOWLEDGE_N_I and
  CAS_I are pins and are synchronised here.
*/
`include "pic_defs.svh"

module pic_ctrl (
  input  wire logic       SYS_CLK_I,
  input  wire logic       NRST_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] DATA_I,
  output      logic [7:0] DATA_O,
  input  wire logic [7:0] IR_I,
  input  wire logic       INTERRUPT_ACKNOWLEDGE_N_I,
  input  wire logic [2:0] CAS_I,
  output      logic       INT_O,
  output      logic [2:0] CAS_O,
  output      logic       CAS_OE_O,
  output      logic [7:0] VEC_O,
  output      logic       VEC_OE_O
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [11:0] s1_ff;
  logic [11:0] s2_ff;
  logic [11:0] s3_ff;
  logic [11:0] filt_ff;
  logic [11:0] nxt_filt;

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      nxt_filt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : filt_ff[i];
    end
  end

  // Idle levels: requests low, acknowledge high
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      s1_ff   <= 12'h100;
      s2_ff   <= 12'h100;
      s3_ff   <= 12'h100;
      filt_ff <= 12'h100;
    end else begin
      s1_ff   <= {CAS_I, INTERRUPT_ACKNOWLEDGE_N_I, IR_I};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  logic [7:0] ir_lvl;
  logic [7:0] ir_rise;
  logic [2:0] cas_in;
  logic       ack_fall;
  logic       ack_rise;

  assign ir_lvl   = nxt_filt[7:0];
  assign ir_rise  = nxt_filt[7:0] & ~filt_ff[7:0];
  assign cas_in   = nxt_filt[11:9];
  assign ack_fall = filt_ff[8] & ~nxt_filt[8];
  assign ack_rise = ~filt_ff[8] & nxt_filt[8];

  // --------------------------------------------------------------------
  // Port decode
  // --------------------------------------------------------------------
  logic wr_even;
  logic wr_odd;
  logic rd_even;
  logic rd_odd;

  always_comb begin
    wr_even = 1'b0;
    wr_odd  = 1'b0;
    rd_even = 1'b0;
    rd_odd  = 1'b0;
    if (ADDR_I == `PIC_PORT_EVEN) begin
      wr_even = WR_I;
      rd_even = RD_I;
    end else if (ADDR_I == `PIC_PORT_ODD) begin
      wr_odd = WR_I;
      rd_odd = RD_I;
    end else if (ADDR_I == `PIC_PORT_EVEN_ALT) begin
      rd_even = RD_I;
    end else if (ADDR_I == `PIC_PORT_ODD_ALT) begin
      rd_odd = RD_I;
    end
  end

  // --------------------------------------------------------------------
  // Configuration and initialization sequence
  // --------------------------------------------------------------------
  pic_pkg::pic_init_e init_ff,  nxt_init;
  logic [4:0]         vbase_ff, nxt_vbase;
  pic_pkg::pic_byte_t cmap_ff,  nxt_cmap;
  pic_pkg::pic_byte_t mask_ff,  nxt_mask;
  logic               level_ff, nxt_level;
  logic               casc_ff,  nxt_casc;
  logic               aeoi_ff,  nxt_aeoi;
  logic               ms_ff,    nxt_ms;
  logic               buf_ff,   nxt_buf;
  logic               sfn_ff,   nxt_sfn;
  logic               smm_ff,   nxt_smm;
  logic               sel_ff,   nxt_sel;
  logic               w1_wr;
  logic               pc_wr;
  logic               ready;
  logic               master;

  assign w1_wr  = wr_even && DATA_I[`PIC_W1_ID] && DATA_I[`PIC_W1_IC4];
  assign ready  = (init_ff == pic_pkg::PIC_INIT_READY);
  assign pc_wr  = wr_even && ready && !DATA_I[`PIC_W1_ID] && !DATA_I[`PIC_SS_FLAG];
  // Unbuffered parts act as master
  assign master = buf_ff ? ms_ff : 1'b1;

  always_comb begin
    nxt_init  = init_ff;
    nxt_vbase = vbase_ff;
    nxt_cmap  = cmap_ff;
    nxt_mask  = mask_ff;
    nxt_level = level_ff;
    nxt_casc  = casc_ff;
    nxt_aeoi  = aeoi_ff;
    nxt_ms    = ms_ff;
    nxt_buf   = buf_ff;
    nxt_sfn   = sfn_ff;
    nxt_smm   = smm_ff;
    nxt_sel   = sel_ff;
    if (w1_wr) begin
      nxt_init  = pic_pkg::PIC_INIT_VEC;
      nxt_level = DATA_I[`PIC_W1_LTIM];
      nxt_casc  = !DATA_I[`PIC_W1_SNGL];
      nxt_mask  = `PIC_RST_MASK;
      nxt_smm   = 1'b0;
      nxt_sel   = 1'b0;
      nxt_sfn   = 1'b0;
    end else if (wr_even && ready && !DATA_I[`PIC_W1_ID] && DATA_I[`PIC_SS_FLAG]) begin
      if (DATA_I[`PIC_SS_ESMM]) begin
        nxt_smm = DATA_I[`PIC_SS_SMM];
      end
      if (DATA_I[`PIC_SS_RR]) begin
        nxt_sel = DATA_I[`PIC_SS_RIS];
      end
    end else if (wr_odd) begin
      case (init_ff)
        pic_pkg::PIC_INIT_VEC: begin
          nxt_vbase = DATA_I[7:3];
          nxt_init  = casc_ff ? pic_pkg::PIC_INIT_CAS : pic_pkg::PIC_INIT_MODE;
        end
        pic_pkg::PIC_INIT_CAS: begin
          nxt_cmap = DATA_I;
          nxt_init = pic_pkg::PIC_INIT_MODE;
        end
        pic_pkg::PIC_INIT_MODE: begin
          // A mode word without bit 0 is ignored
          if (DATA_I[`PIC_W4_UPM]) begin
            nxt_aeoi = DATA_I[`PIC_W4_AEOI];
            nxt_ms   = DATA_I[`PIC_W4_MS];
            nxt_buf  = DATA_I[`PIC_W4_BUF];
            nxt_sfn  = DATA_I[`PIC_W4_SFNM];
            nxt_init = pic_pkg::PIC_INIT_READY;
          end
        end
        pic_pkg::PIC_INIT_READY: begin
          nxt_mask = DATA_I;
        end
        default: begin
          nxt_init = init_ff;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      init_ff  <= pic_pkg::PIC_INIT_IDLE;
      vbase_ff <= 5'h00;
      cmap_ff  <= 8'h00;
      mask_ff  <= `PIC_RST_MASK;
      level_ff <= 1'b0;
      casc_ff  <= 1'b0;
      aeoi_ff  <= 1'b0;
      ms_ff    <= 1'b0;
      buf_ff   <= 1'b0;
      sfn_ff   <= 1'b0;
      smm_ff   <= 1'b0;
      sel_ff   <= 1'b0;
    end else begin
      init_ff  <= nxt_init;
      vbase_ff <= nxt_vbase;
      cmap_ff  <= nxt_cmap;
      mask_ff  <= nxt_mask;
      level_ff <= nxt_level;
      casc_ff  <= nxt_casc;
      aeoi_ff  <= nxt_aeoi;
      ms_ff    <= nxt_ms;
      buf_ff   <= nxt_buf;
      sfn_ff   <= nxt_sfn;
      smm_ff   <= nxt_smm;
      sel_ff   <= nxt_sel;
    end
  end

  // --------------------------------------------------------------------
  // Priority resolver
  // --------------------------------------------------------------------
  pic_pkg::pic_byte_t irr_ff, nxt_irr;
  pic_pkg::pic_byte_t isr_ff, nxt_isr;
  pic_pkg::pic_line_t low_ff, nxt_low;
  logic               rot_ff, nxt_rot;
  pic_res_if          res ();

  assign res.req  = irr_ff;
  assign res.in_service_status  = isr_ff;
  assign res.mask = mask_ff;
  assign res.smap = cmap_ff;
  assign res.low  = low_ff;
  assign res.smm  = smm_ff;
  assign res.special_nesting_select  = sfn_ff && master && casc_ff;

  pic_resolver u_resolver (
    .r (res.res)
  );

  // --------------------------------------------------------------------
  // Acknowledge sequence
  // --------------------------------------------------------------------
  pic_pkg::pic_ack_e  ack_ff,   nxt_ack;
  pic_pkg::pic_line_t win_ff,   nxt_win;
  logic               took_ff,  nxt_took;
  logic [2:0]         cas_ff,   nxt_cas;
  logic               casoe_ff, nxt_casoe;
  pic_pkg::pic_byte_t vec_ff,   nxt_vec;
  logic               vecoe_ff, nxt_vecoe;
  logic               int_ff,   nxt_int;
  pic_pkg::pic_byte_t isr_set;
  logic               aeoi_evt;
  logic               to_slave;

  assign to_slave = casc_ff && cmap_ff[res.win];

  always_comb begin
    nxt_ack   = ack_ff;
    nxt_win   = win_ff;
    nxt_took  = took_ff;
    nxt_cas   = cas_ff;
    nxt_casoe = casoe_ff;
    nxt_vec   = vec_ff;
    nxt_vecoe = vecoe_ff;
    isr_set   = 8'h00;
    aeoi_evt  = 1'b0;
    nxt_int   = ready && res.int_req && (ack_ff == pic_pkg::PIC_ACK_IDLE);
    case (ack_ff)
      pic_pkg::PIC_ACK_IDLE: begin
        if (ack_fall) begin
          nxt_ack  = pic_pkg::PIC_ACK_ONE;
          nxt_took = 1'b0;
          if (master) begin
            nxt_win  = res.int_req ? res.win : `PIC_SPURIOUS;
            nxt_took = res.int_req;
            isr_set  = res.int_req ? (8'h01 << res.win) : 8'h00;
            if (res.int_req && to_slave) begin
              nxt_cas   = res.win;
              nxt_casoe = 1'b1;
            end
          end
        end
      end
      pic_pkg::PIC_ACK_ONE: begin
        if (ack_fall) begin
          nxt_ack = pic_pkg::PIC_ACK_TWO;
          if (master) begin
            nxt_vec   = {vbase_ff, win_ff};
            nxt_vecoe = !casoe_ff;
          end else if (cas_in == cmap_ff[2:0]) begin
            nxt_win   = res.int_req ? res.win : `PIC_SPURIOUS;
            nxt_took  = res.int_req;
            isr_set   = res.int_req ? (8'h01 << res.win) : 8'h00;
            nxt_vec   = {vbase_ff, nxt_win};
            nxt_vecoe = 1'b1;
          end
        end
      end
      pic_pkg::PIC_ACK_TWO: begin
        if (ack_rise) begin
          nxt_ack   = pic_pkg::PIC_ACK_IDLE;
          nxt_vecoe = 1'b0;
          nxt_casoe = 1'b0;
          aeoi_evt  = aeoi_ff && took_ff;
        end
      end
      default: begin
        nxt_ack = pic_pkg::PIC_ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      ack_ff   <= pic_pkg::PIC_ACK_IDLE;
      win_ff   <= 3'h0;
      took_ff  <= 1'b0;
      cas_ff   <= 3'h0;
      casoe_ff <= 1'b0;
      vec_ff   <= 8'h00;
      vecoe_ff <= 1'b0;
      int_ff   <= 1'b0;
    end else begin
      ack_ff   <= nxt_ack;
      win_ff   <= nxt_win;
      took_ff  <= nxt_took;
      cas_ff   <= nxt_cas;
      casoe_ff <= nxt_casoe;
      vec_ff   <= nxt_vec;
      vecoe_ff <= nxt_vecoe;
      int_ff   <= nxt_int;
    end
  end

  // --------------------------------------------------------------------
  // Request, in-service and rotation state
  // --------------------------------------------------------------------
  pic_pkg::pic_byte_t isr_clr;
  pic_pkg::pic_line_t cmd_line;

  assign cmd_line = DATA_I[2:0];

  always_comb begin
    isr_clr = 8'h00;
    nxt_low = low_ff;
    nxt_rot = rot_ff;
    // Edge mode holds a request until taken or the line drops
    nxt_irr = level_ff ? ir_lvl : (((irr_ff & ~isr_set) | ir_rise) & ir_lvl);
    if (pc_wr) begin
      case (DATA_I[7:5])
        `PIC_PC_AEOI_SET: nxt_rot = 1'b1;
        `PIC_PC_AEOI_CLR: nxt_rot = 1'b0;
        `PIC_PC_EOI: isr_clr = res.top_any ? (8'h01 << res.top) : 8'h00;
        `PIC_PC_LINE_SPECIFIC_END: isr_clr = 8'h01 << cmd_line;
        `PIC_PC_ROT_EOI: begin
          if (res.top_any) begin
            isr_clr = 8'h01 << res.top;
            nxt_low = res.top;
          end
        end
        `PIC_PC_SET_PRI: nxt_low = cmd_line;
        `PIC_PC_ROT_LINE_SPECIFIC_END: begin
          isr_clr = 8'h01 << cmd_line;
          nxt_low = cmd_line;
        end
        default: nxt_low = low_ff;
      endcase
    end
    if (aeoi_evt) begin
      isr_clr = isr_clr | (8'h01 << win_ff);
      if (rot_ff) begin
        nxt_low = win_ff;
      end
    end
    // A new in-service bit wins over a clear in the same cycle
    nxt_isr = (isr_ff & ~isr_clr) | isr_set;
    if (w1_wr) begin
      nxt_isr = 8'h00;
      nxt_low = `PIC_RST_LOWEST;
      nxt_rot = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      irr_ff <= 8'h00;
      isr_ff <= 8'h00;
      low_ff <= `PIC_RST_LOWEST;
      rot_ff <= 1'b0;
    end else begin
      irr_ff <= nxt_irr;
      isr_ff <= nxt_isr;
      low_ff <= nxt_low;
      rot_ff <= nxt_rot;
    end
  end

  // --------------------------------------------------------------------
  // Status reads
  // --------------------------------------------------------------------
  pic_pkg::pic_byte_t rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_odd) begin
      nxt_rdata = mask_ff;
    end else if (rd_even) begin
      nxt_rdata = sel_ff ? isr_ff : irr_ff;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign DATA_O   = rdata_ff;
  assign INT_O    = int_ff;
  assign CAS_O    = cas_ff;
  assign CAS_OE_O = casoe_ff;
  assign VEC_O    = vec_ff;
  assign VEC_OE_O = vecoe_ff;

endmodule

// ### pic_ctrl_monitor.sv
/* Port checker of pic_ctrl, bound into it.
   Assumes one clock and a synchronous low reset. */
module pic_ctrl_monitor (
  input wire logic       SYS_CLK_I,
  input wire logic       NRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] DATA_I,
  input wire logic [7:0] DATA_O,
  input wire logic       INTERRUPT_ACKNOWLEDGE_N_I,
  input wire logic       INT_O,
  input wire logic [7:0] VEC_O,
  input wire logic       VEC_OE_O
);
  // ------
  // Init mirror and properties
  // ------
  logic [1:0] stg_ff;
  logic       cas_ff;
  logic       done_ff;
  logic [7:0] base_ff;
  logic [7:0] mask_ff;
  // Mirrors init so checks need no internal hooks
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      stg_ff <= 2'h0;
      cas_ff <= 1'b0;
      done_ff <= 1'b0;
      base_ff <= 8'h00;
      mask_ff <= 8'h00;
    end else if (WR_I && ADDR_I == 8'hc0 && DATA_I[4] && DATA_I[0]) begin
      stg_ff <= 2'h1;
      cas_ff <= !DATA_I[1];
      mask_ff <= 8'h00;
    end else if (WR_I && ADDR_I == 8'hc2) begin
      if (stg_ff == 2'h1) base_ff <= DATA_I;
      if (stg_ff == 2'h1) stg_ff <= cas_ff ? 2'h2 : 2'h3;
      if (stg_ff == 2'h2) stg_ff <= 2'h3;
      if (stg_ff == 2'h3 && DATA_I[0]) stg_ff <= 2'h0;
      if (stg_ff == 2'h3 && DATA_I[0]) done_ff <= 1'b1;
      if (stg_ff == 2'h0 && done_ff) mask_ff <= DATA_I;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  rst_quiet_a: assert property (disable iff (1'b0) !NRST_I |=>
    !INT_O && !VEC_OE_O && DATA_O == 8'h00) else $error("busy in reset");
  int_uninit_a: assert property (!done_ff |-> !INT_O)
    else $error("int before init");
  mask_read_a: assert property (RD_I && ADDR_I[7:3] == 5'h18 && ADDR_I[1:0] == 2'h2
    |=> DATA_O == $past(mask_ff)) else $error("bad mask read");
  data_hold_a: assert property (!RD_I |=> $stable(DATA_O))
    else $error("read data moved");
  vec_base_a: assert property (VEC_OE_O |-> VEC_O[7:3] == base_ff[7:3])
    else $error("bad vector base");
  vec_steady_a: assert property (VEC_OE_O && $past(VEC_OE_O) |-> $stable(VEC_O))
    else $error("vector moved");
  vec_cause_a: assert property ($rose(VEC_OE_O) |-> !$past(INTERRUPT_ACKNOWLEDGE_N_I, 3))
    else $error("vector without ack");
  vec_release_a: assert property ($rose(INTERRUPT_ACKNOWLEDGE_N_I) && VEC_OE_O |-> ##[1:8] !VEC_OE_O)
    else $error("vector held");
  int_drop_a: assert property ($fell(INTERRUPT_ACKNOWLEDGE_N_I) && INT_O |-> ##[2:8] !INT_O)
    else $error("int held after ack");
endmodule
bind pic_ctrl pic_ctrl_monitor mon_u (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .DATA_I(DATA_I), .DATA_O(DATA_O),
  .INTERRUPT_ACKNOWLEDGE_N_I(INTERRUPT_ACKNOWLEDGE_N_I), .INT_O(INT_O), .VEC_O(VEC_O), .VEC_OE_O(VEC_OE_O));

// ### pic_host_model.sv
/* Host model: one two-pulse acknowledge per rise of go_i.
   Assumes the controller's clock; 9 clocks per phase. */
module pic_host_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       vec_oe_i,
  input  wire logic [7:0] vec_i,
  output      logic       interrupt_acknowledge_n_o,
  output      logic       busy_o,
  output      logic [7:0] vec_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Acknowledge cycle
  // ------
  initial interrupt_acknowledge_n_o = 1'b1;
  initial busy_o = 1'b0;
  initial vec_o = 8'h00;
  // Low, high, low, high; phases well over 3 clocks for the pin filter
  always @(posedge go_i) begin
    busy_o = 1'b1;
    vec_o = 8'hxx;
    repeat (4) begin
      @(posedge clk_i);
      #1 interrupt_acknowledge_n_o = !interrupt_acknowledge_n_o;
      repeat (8) begin
        @(posedge clk_i);
        if (vec_oe_i) vec_o = vec_i;
      end
    end
    busy_o = 1'b0;
  end
endmodule

// ### tb.sv
/* Self-checking bench of pic_ctrl with a host model on the ack pin.
   Assumes the design files and the two files above compile first. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Bench
  // ------
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] irq = 8'h00;
  logic [7:0] rdat;
  logic [7:0] vec;
  logic [7:0] got;
  logic [2:0] cas;
  logic [2:0] cas_in = 3'h0;
  logic       interrupt_acknowledge_n;
  logic       int_o;
  logic       cas_oe;
  logic       vec_oe;
  logic       busy;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #12.5 clk = !clk;
  pic_ctrl dut_u (.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WR_I(wr),
    .RD_I(rd), .DATA_I(wdat), .DATA_O(rdat), .IR_I(irq), .INTERRUPT_ACKNOWLEDGE_N_I(interrupt_acknowledge_n),
    .CAS_I(cas_in), .INT_O(int_o), .CAS_O(cas), .CAS_OE_O(cas_oe), .VEC_O(vec),
    .VEC_OE_O(vec_oe));
  pic_host_model host_u (.clk_i(clk), .go_i(go), .vec_oe_i(vec_oe),
    .vec_i(vec), .interrupt_acknowledge_n_o(interrupt_acknowledge_n), .busy_o(busy), .vec_o(got));
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run needs about 610 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string msg);
    comparisons++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, act, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdat = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rdat, exp, "read");
  endtask
  task automatic idle(input int n, input logic exp);
    repeat (n) @(posedge clk);
    #1 chk({7'h00, int_o}, {7'h00, exp}, "int");
  endtask
  task automatic ack(input logic [7:0] exp);
    idle(12, 1'b1);
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    while (busy) @(posedge clk);
    chk(got, exp, "vector");
  endtask
  task automatic t_init();
    chk({5'h00, int_o, vec_oe, cas_oe}, 8'h00, "pins");
    rd_reg(8'hc2, 8'h00);
    wr_reg(8'hc0, 8'h13);
    wr_reg(8'hc2, 8'h48);
    wr_reg(8'hc2, 8'h0c);
    wr_reg(8'hc2, 8'h0d);
    wr_reg(8'hc2, 8'ha5);
    rd_reg(8'hc2, 8'ha5);
    rd_reg(8'hc6, 8'ha5);
    wr_reg(8'hc6, 8'h5a);
    rd_reg(8'hc2, 8'ha5);
    wr_reg(8'hc2, 8'h00);
  endtask
  task automatic t_nest();
    irq = 8'h24;
    ack(8'h4a);
    idle(12, 1'b0);
    wr_reg(8'hc0, 8'h0a);
    rd_reg(8'hc0, 8'h20);
    wr_reg(8'hc0, 8'h0b);
    rd_reg(8'hc0, 8'h04);
    rd_reg(8'hc0, 8'h04);
    wr_reg(8'hc0, 8'h68);
    ack(8'h4d);
    wr_reg(8'hc0, 8'h48);
    wr_reg(8'hc0, 8'h20);
    wr_reg(8'hc0, 8'h20);
    rd_reg(8'hc4, 8'h00);
    irq = 8'h00;
  endtask
  task automatic t_rotate();
    wr_reg(8'hc0, 8'hc4);
    irq = 8'h48;
    ack(8'h4e);
    wr_reg(8'hc0, 8'he6);
    ack(8'h4b);
    wr_reg(8'hc0, 8'he3);
    rd_reg(8'hc0, 8'h00);
    irq = 8'h00;
  endtask
  task automatic t_auto();
    wr_reg(8'hc0, 8'h13);
    wr_reg(8'hc2, 8'h48);
    wr_reg(8'hc2, 8'h0f);
    wr_reg(8'hc0, 8'h80);
    irq = 8'h01;
    ack(8'h48);
    wr_reg(8'hc0, 8'h0b);
    rd_reg(8'hc0, 8'h00);
    irq = 8'h00;
    idle(8, 1'b0);
    irq = 8'h03;
    ack(8'h49);
    wr_reg(8'hc0, 8'h00);
    irq = 8'h00;
  endtask
  // Master with a slave on line 5, level sense, special nesting
  task automatic t_casc();
    wr_reg(8'hc0, 8'h19);
    wr_reg(8'hc2, 8'h48);
    wr_reg(8'hc2, 8'h20);
    wr_reg(8'hc2, 8'h1d);
    irq = 8'h20;
    ack(8'hxx);
    chk({5'h00, cas}, 8'h05, "cas");
    // Same slave line may interrupt again only in special nesting
    idle(12, 1'b1);
    wr_reg(8'hc0, 8'ha0);
    irq = 8'h60;
    ack(8'h4e);
    irq = 8'h00;
    wr_reg(8'hc0, 8'h20);
  endtask
  // Slave with identity 5: vector only when the cascade lines match
  task automatic t_slave();
    cas_in = 3'h5;
    wr_reg(8'hc0, 8'h11);
    wr_reg(8'hc2, 8'h48);
    wr_reg(8'hc2, 8'h05);
    wr_reg(8'hc2, 8'h09);
    irq = 8'h04;
    ack(8'h4a);
    wr_reg(8'hc0, 8'h20);
    cas_in = 3'h2;
    irq = 8'h0c;
    ack(8'hxx);
    irq = 8'h00;
    cas_in = 3'h0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    t_init();
    $display("end init");
    t_nest();
    $display("end nest");
    t_rotate();
    $display("end rotate");
    t_auto();
    $display("end auto");
    t_casc();
    $display("end casc");
    t_slave();
    $display("end slave");
    tally_and_finish();
  end
endmodule
